// >>> muxed_port_regs.svh
`ifndef MUXED_PORT_REGS_SVH
`define MUXED_PORT_REGS_SVH

// ----------------------------------------
// Register word offsets (byte address = 4 * index)
// ----------------------------------------
`define PORT_IDX_LEVEL 3'h0
`define PORT_IDX_LATCH 3'h1
`define PORT_IDX_DIR 3'h2
`define PORT_IDX_MEMCTL 3'h3
`define PORT_IDX_SPCTL 3'h4
`define PORT_IDX_CFG 3'h5
`define PORT_IDX_SHUT 3'h6

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MEMCTL_BUS_DIS_BIT 7
`define SPCTL_MODE_BIT 4
`define CFG_ALT_PIN_BIT 0
`define CFG_SINGLE_CHIP_BIT 1
`define CFG_PINS80_BIT 2
`define SHUT_TRI2_BIT 0
`define SHUT_TRI3_BIT 1
`define DIR_RESET 8'hFF
`define LATCH_RESET 8'h00
`define MEMCTL_RESET 8'h00
`define SPCTL_RESET 8'h00
`define CFG_RESET 8'h02
`define SHUT_RESET 8'h00
`define PIN_SEVEN 7
`define PWM3_LO 3
`define PWM3_HI 4
`define PWM2_LO 0
`define PWM2_HI 2
`define SLAVE_RD_PIN 0
`define SLAVE_WR_PIN 1
`define SLAVE_CS_PIN 2
`define PIN_RESET 8'h00
`define BUS_IN_IDLE 8'h00
`define READ_RESET 32'h0000_0000
`define READ_UNMAPPED 32'h0000_0000

`endif

// >>> muxed_port_pkg.sv
package muxed_port_pkg;
  // Bus slave phases
  typedef enum logic [0:0] {
    bus_idle,
    bus_done
  } bus_state_t;
endpackage

// >>> muxed_bidir_port_byte.sv
// How it works
// - Direction bit one makes the pin an input with its driver off.
// - Direction bit zero drives the pin from its output latch bit.
// - Eight pins, each with its own independent direction bit.
// - Output latch is mapped; reading it returns latched value, not pins.
// - After reset every pin is a digital input.
// - Single-chip with alt-pin bit clear: pin seven carries capture/compare unit 2.
// - With 80 pins and bus enabled, pins carry bus bits 15..8 until disabled.
// - While the bus owns the port, direction bits are ignored.
// - Slave port mode makes pins 0..2 read, write and select inputs.
// - Bus address/data output wins over PWM and latch on pins 0..4.
// - With the bus enabled, read data bits 8..15 come from pins 0..7.
// - PWM unit 2 channels D, C, B drive pins 0..2, tri-state on shutdown.
// - PWM unit 3 channels C, B drive pins 3..4, tri-state on shutdown.
// - Functions that override direction ignore the direction bit.
`timescale 1ns/1ps
`default_nettype none
`include "muxed_port_regs.svh"

module muxed_bidir_port_byte
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // External memory bus high byte
  input wire logic [7:0] ext_bus_high_byte_out,
  input wire logic [7:0] ext_bus_high_byte_oe,
  output logic [7:0] ext_bus_high_byte_in,
  // Enhanced PWM units
  input wire logic pwm2_chan_d,
  input wire logic pwm2_chan_c,
  input wire logic pwm2_chan_b,
  input wire logic pwm2_enable,
  input wire logic pwm2_shutdown,
  input wire logic pwm3_chan_c,
  input wire logic pwm3_chan_b,
  input wire logic pwm3_enable,
  input wire logic pwm3_shutdown,
  // Capture/compare unit 2
  input wire logic capture_compare_unit2_out,
  input wire logic capture_compare_unit2_en,
  output logic capture_compare_unit2_in,
  // Parallel slave port strobes
  output logic slave_rd_strobe,
  output logic slave_wr_strobe,
  output logic slave_cs_strobe,
  output logic slave_port_active
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pin_direction_reg_q;
  logic [7:0] latch_q;
  logic [7:0] memory_ctrl_reg_q;
  logic [7:0] slave_port_ctrl_reg_q;
  logic [7:0] cfg_q;
  logic [7:0] shut_q;
  logic [7:0] sync1_q;
  logic [7:0] pin_level_reg_q;
  muxed_port_pkg::bus_state_t bus_q;
  logic [7:0] out_d;
  logic [7:0] oe_d;
  logic bus_owns;
  logic slave_port_mode;
  logic capture_alt_pin_cfg;
  logic [2:0] reg_idx;
  logic access;
  logic write_req;
  logic wr_latch;
  logic wr_dir;
  logic wr_memctl;
  logic wr_spctl;
  logic wr_cfg;
  logic wr_shut;
  logic pwm2_owns;
  logic pwm3_owns;
  logic ccp_owns;

  // Word index decode of a byte address
  function automatic logic [2:0] word_index(input logic [4:0] addr);
    word_index = addr[4:2];
  endfunction

  // Bit select of a control register
  function automatic logic cfg_bit(input logic [7:0] r, input int pos);
    cfg_bit = r[pos];
  endfunction

  // Write strobe for one register index
  function automatic logic write_hit(input logic req, input logic [2:0] idx, input logic [2:0] sel);
    write_hit = req && (idx == sel);
  endfunction

  // Decoded register index and a request the slave may take now
  assign reg_idx = word_index(avs_address);
  assign access = (avs_read | avs_write) && (bus_q == muxed_port_pkg::bus_idle);
  // Bus owns port only on the 80-pin part with the bus not disabled
  assign bus_owns = cfg_bit(cfg_q, `CFG_PINS80_BIT)
    && !cfg_bit(memory_ctrl_reg_q, `MEMCTL_BUS_DIS_BIT);
  // Mode and pin configuration bits
  assign slave_port_mode = cfg_bit(slave_port_ctrl_reg_q, `SPCTL_MODE_BIT);
  assign capture_alt_pin_cfg = cfg_bit(cfg_q, `CFG_ALT_PIN_BIT);

  // Write strobes, one per register, on the edge that takes the request
  assign write_req = access && avs_write;
  assign wr_latch = write_hit(write_req, reg_idx, `PORT_IDX_LEVEL)
    || write_hit(write_req, reg_idx, `PORT_IDX_LATCH);
  assign wr_dir = write_hit(write_req, reg_idx, `PORT_IDX_DIR);
  assign wr_memctl = write_hit(write_req, reg_idx, `PORT_IDX_MEMCTL);
  assign wr_spctl = write_hit(write_req, reg_idx, `PORT_IDX_SPCTL);
  assign wr_cfg = write_hit(write_req, reg_idx, `PORT_IDX_CFG);
  assign wr_shut = write_hit(write_req, reg_idx, `PORT_IDX_SHUT);

  // Peripheral outputs claim their pins only when the first pin of their group (0, 3 or 7) is set as output
  assign pwm2_owns = pwm2_enable && !pin_direction_reg_q[`PWM2_LO];
  assign pwm3_owns = pwm3_enable && !pin_direction_reg_q[`PWM3_LO];
  // Compare output reaches pin seven only in single-chip mode on the default pin
  assign ccp_owns = cfg_bit(cfg_q, `CFG_SINGLE_CHIP_BIT) && !capture_alt_pin_cfg
    && capture_compare_unit2_en && !pin_direction_reg_q[`PIN_SEVEN];

  // ----------------------------------------
  // Bus slave handshake
  // ----------------------------------------
  // One wait cycle, then answer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bus_q <= muxed_port_pkg::bus_idle;
    else if (access)
      bus_q <= muxed_port_pkg::bus_done;
    else
      bus_q <= muxed_port_pkg::bus_idle;
  end

  // Wait request high until the answer cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !access;
  end

  // Read data mux
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= `READ_RESET;
    else if (access && avs_read)
    begin
      case (reg_idx)
        `PORT_IDX_LEVEL: avs_readdata <= {24'h000000, pin_level_reg_q};
        `PORT_IDX_LATCH: avs_readdata <= {24'h000000, latch_q};
        `PORT_IDX_DIR: avs_readdata <= {24'h000000, pin_direction_reg_q};
        `PORT_IDX_MEMCTL: avs_readdata <= {24'h000000, memory_ctrl_reg_q};
        `PORT_IDX_SPCTL: avs_readdata <= {24'h000000, slave_port_ctrl_reg_q};
        `PORT_IDX_CFG: avs_readdata <= {24'h000000, cfg_q};
        `PORT_IDX_SHUT: avs_readdata <= {24'h000000, shut_q};
        default: avs_readdata <= `READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Output latch written through port or latch address
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      latch_q <= `LATCH_RESET;
    else if (wr_latch)
      latch_q <= avs_writedata[7:0];
  end

  // Direction register, all inputs after reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pin_direction_reg_q <= `DIR_RESET;
    else if (wr_dir)
      pin_direction_reg_q <= avs_writedata[7:0];
  end

  // Memory control, bus disable bit hands the pins back to the port
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      memory_ctrl_reg_q <= `MEMCTL_RESET;
    else if (wr_memctl)
      memory_ctrl_reg_q <= avs_writedata[7:0];
  end

  // Slave port control, mode bit claims pins 0..2
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      slave_port_ctrl_reg_q <= `SPCTL_RESET;
    else if (wr_spctl)
      slave_port_ctrl_reg_q <= avs_writedata[7:0];
  end

  // Configuration: alternate pin, single-chip mode, 80-pin part
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= `CFG_RESET;
    else if (wr_cfg)
      cfg_q <= avs_writedata[7:0];
  end

  // Shutdown tri-state enables of both PWM units
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      shut_q <= `SHUT_RESET;
    else if (wr_shut)
      shut_q <= avs_writedata[7:0];
  end

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= `PIN_RESET;
      pin_level_reg_q <= `PIN_RESET;
    end
    else
    begin
      sync1_q <= pin_in;
      pin_level_reg_q <= sync1_q;
    end
  end

  // Bus read data taken from the pins while the bus owns the port
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ext_bus_high_byte_in <= `PIN_RESET;
    else
      ext_bus_high_byte_in <= bus_owns ? pin_level_reg_q : `BUS_IN_IDLE;
  end

  // Slave port strobes, gated by the mode bit
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_rd_strobe <= 1'b0;
      slave_wr_strobe <= 1'b0;
      slave_cs_strobe <= 1'b0;
      slave_port_active <= 1'b0;
    end
    else
    begin
      slave_rd_strobe <= slave_port_mode & pin_level_reg_q[`SLAVE_RD_PIN];
      slave_wr_strobe <= slave_port_mode & pin_level_reg_q[`SLAVE_WR_PIN];
      slave_cs_strobe <= slave_port_mode & pin_level_reg_q[`SLAVE_CS_PIN];
      slave_port_active <= slave_port_mode;
    end
  end

  // Capture input always sees the synced level of pin seven
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      capture_compare_unit2_in <= 1'b0;
    else
      capture_compare_unit2_in <= pin_level_reg_q[`PIN_SEVEN];
  end

  // ----------------------------------------
  // Output driver selection
  // ----------------------------------------
  // Priority: bus, slave strobes, PWM / unit 2, then port latch
  always_comb
  begin
    // Port latch and direction bits by default
    for (int i = 0; i < 8; i++)
    begin
      out_d[i] = latch_q[i];
      oe_d[i] = !pin_direction_reg_q[i];
    end
    // PWM unit 2 ahead of the latch on pins 0..2
    if (pwm2_owns)
    begin
      out_d[`PWM2_HI:`PWM2_LO] = {pwm2_chan_b, pwm2_chan_c, pwm2_chan_d};
      if (pwm2_shutdown && cfg_bit(shut_q, `SHUT_TRI2_BIT))
        oe_d[`PWM2_HI:`PWM2_LO] = 3'h0;
    end
    // PWM unit 3 ahead of the latch on pins 3..4
    if (pwm3_owns)
    begin
      out_d[`PWM3_HI:`PWM3_LO] = {pwm3_chan_b, pwm3_chan_c};
      if (pwm3_shutdown && cfg_bit(shut_q, `SHUT_TRI3_BIT))
        oe_d[`PWM3_HI:`PWM3_LO] = 2'h0;
    end
    // Compare output of unit 2 on pin seven
    if (ccp_owns)
      out_d[`PIN_SEVEN] = capture_compare_unit2_out;
    // Slave strobes are inputs whatever the direction bits hold
    if (slave_port_mode)
      oe_d[`SLAVE_CS_PIN:`SLAVE_RD_PIN] = 3'h0;
    // The memory bus overrides everything, pin by pin
    if (bus_owns)
    begin
      out_d = ext_bus_high_byte_out;
      oe_d = ext_bus_high_byte_oe;
    end
  end

  // Registered pin data
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pin_out <= `PIN_RESET;
    else
      pin_out <= out_d;
  end

  // Registered pin enables, all released at reset so every pin is an input
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pin_oe <= `PIN_RESET;
    else
      pin_oe <= oe_d;
  end

endmodule
`default_nettype wire

// >>> muxed_bidir_port_byte_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------
// Port byte checker
// -------------------------------
module port_byte_checker
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Pins and functions
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_bus_high_byte_out,
  input wire logic [7:0] ext_bus_high_byte_oe,
  input wire logic [7:0] ext_bus_high_byte_in,
  input wire logic slave_rd_strobe,
  input wire logic slave_wr_strobe,
  input wire logic slave_cs_strobe,
  input wire logic slave_port_active
);
  // One clock domain
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Bus answers
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  // Pins after reset
  property p_reset_in;
    $rose(rst_n) |-> (pin_oe == 8'h00) [*3];
  endproperty
  a_reset_in: assert property (p_reset_in) else $error("pin driven after reset");
  // Bus ownership overrides direction and other drivers
  property p_bus_oe;
    ext_bus_high_byte_in != 8'h00 |-> pin_oe == $past(ext_bus_high_byte_oe);
  endproperty
  a_bus_oe: assert property (p_bus_oe) else $error("bus enable not on pins");
  property p_bus_out;
    ext_bus_high_byte_in != 8'h00 |-> (pin_out & pin_oe) == ($past(ext_bus_high_byte_out) & pin_oe);
  endproperty
  a_bus_out: assert property (p_bus_out) else $error("bus data not on pins");
  // Slave port controls
  property p_slave_in;
    slave_port_active && $past(slave_port_active) && ext_bus_high_byte_in == 8'h00 |-> pin_oe[2:0] == 3'h0;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("strobe pin driven");
  property p_strobe;
    slave_rd_strobe || slave_wr_strobe || slave_cs_strobe |-> slave_port_active || $past(slave_port_active);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe outside slave mode");
endmodule

bind muxed_bidir_port_byte port_byte_checker u_chk (.mclk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .pin_out, .pin_oe, .ext_bus_high_byte_out, .ext_bus_high_byte_oe, .ext_bus_high_byte_in,
  .slave_rd_strobe, .slave_wr_strobe, .slave_cs_strobe, .slave_port_active);
`default_nettype wire

// >>> pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------
// Pins with pull-ups and a far driver
// -------------------------------
module pin_partner
(
  // Both drivers
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Level seen by the device
  output logic [7:0] pin_in
);
  // Released pin with its far driver off floats up to the pull-up level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule
`default_nettype wire

// >>> muxed_bidir_port_byte_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module muxed_bidir_port_byte_tb_top;
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows[6] = '{'{5'h04, 8'hA5, 8'hA5}, '{5'h08, 8'h3C, 8'h3C}, '{5'h0C, 8'h80, 8'h80},
    '{5'h10, 8'h10, 8'h10}, '{5'h10, 8'h00, 8'h00}, '{5'h1C, 8'hFF, 8'h00}};
  logic [4:0] rst_a[4] = '{5'h08, 5'h04, 5'h14, 5'h0C};
  logic [7:0] rst_v[4] = '{8'hFF, 8'h00, 8'h02, 8'h00};
  logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, ccp_out = 0, ccp_en = 0, ccp_in;
  logic [4:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [7:0] pin_in, pin_out, pin_oe, ext_val = 0, ext_en = 0, bus_out = 0, bus_oe = 0, bus_in;
  logic [8:0] pwm = 0;
  wire [3:0] slv;
  int failures = 0, compares = 0;
  // -------------------------------
  // Design, pins and clock
  // -------------------------------
  muxed_bidir_port_byte DUT (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .ext_bus_high_byte_out(bus_out), .ext_bus_high_byte_oe(bus_oe),
    .ext_bus_high_byte_in(bus_in), .pwm2_chan_d(pwm[0]), .pwm2_chan_c(pwm[1]), .pwm2_chan_b(pwm[2]),
    .pwm2_enable(pwm[3]), .pwm2_shutdown(pwm[4]), .pwm3_chan_c(pwm[5]), .pwm3_chan_b(pwm[6]),
    .pwm3_enable(pwm[7]), .pwm3_shutdown(pwm[8]), .capture_compare_unit2_out(ccp_out),
    .capture_compare_unit2_en(ccp_en), .capture_compare_unit2_in(ccp_in), .slave_rd_strobe(slv[3]),
    .slave_wr_strobe(slv[2]), .slave_cs_strobe(slv[1]), .slave_port_active(slv[0]));
  pin_partner far (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
  // Clock
  always #2.5 mclk = ~mclk;
  // -------------------------------
  // Bus cycles and ending
  // -------------------------------
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    // Hold the request until waitrequest is sampled low; the watchdog ends a hang
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata;
  endtask
  // Release the bus and let pins settle
  task automatic settle;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task finish_test;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #20000;
    failures++;
    finish_test;
  end
  // -------------------------------
  // Tests
  // -------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i])
    begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 8'h00);
      `CHK(q, {24'h0, rows[i].e})
    end
    settle;
    rst_n <= 1'b0;
    settle;
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (rst_a[i])
    begin
      bus(0, rst_a[i], 8'h00);
      `CHK(q, {24'h0, rst_v[i]})
    end
    `CHK(pin_oe, 8'h00)
    ext_en <= 8'hF0;
    ext_val <= 8'h90;
    bus(1, 5'h08, 8'hF0);
    bus(1, 5'h04, 8'h5A);
    settle;
    `CHK(pin_oe, 8'h0F)
    `CHK(pin_out & 8'h0F, 8'h0A)
    `CHK(ccp_in, 1'b1)
    bus(0, 5'h00, 8'h00);
    `CHK(q, 32'h9A)
    bus(0, 5'h04, 8'h00);
    `CHK(q, 32'h5A)
    ext_en <= 8'h70;
    ccp_out <= 1'b1;
    ccp_en <= 1'b1;
    bus(1, 5'h08, 8'h70);
    settle;
    `CHK({pin_oe[7], pin_out[7]}, 2'b11)
    bus(1, 5'h14, 8'h03);
    settle;
    `CHK(pin_out[7], 1'b0)
    ext_en <= 8'h00;
    pwm <= 9'h0AD;
    bus(1, 5'h08, 8'h00);
    settle;
    `CHK(pin_out & 8'h1F, 8'h0D)
    pwm <= 9'h1BD;
    bus(1, 5'h18, 8'h03);
    settle;
    `CHK(pin_oe & 8'h1F, 8'h00)
    ext_en <= 8'hF0;
    bus_oe <= 8'h0F;
    bus_out <= 8'h05;
    bus(1, 5'h14, 8'h06);
    settle;
    `CHK(pin_oe, 8'h0F)
    `CHK(pin_out & 8'h0F, 8'h05)
    `CHK(bus_in, 8'h95)
    bus(1, 5'h0C, 8'h80);
    settle;
    `CHK(pin_oe, 8'hE0)
    ext_en <= 8'h07;
    ext_val <= 8'h05;
    bus(1, 5'h08, 8'h07);
    bus(1, 5'h10, 8'h10);
    settle;
    `CHK(slv, 4'b1011)
    finish_test;
  end
endmodule
`default_nettype wire
